// >>> design/sleep_ctrl_pkg.sv
// package: sleep modes, clock enable bundle, reset values
package sleep_ctrl_pkg;
   // sleep mode select codes (one value per mode)
   typedef enum logic [2:0] {
      SEL_IDLE = 3'h0,
      SEL_ADC_NR = 3'h1,
      SEL_PWR_DOWN = 3'h2,
      SEL_PWR_SAVE = 3'h3,
      SEL_STANDBY = 3'h6
   } sleep_sel_t;

   // controller state, one-hot
   typedef enum logic [5:0] {
      ST_ACTIVE = 6'h01,
      ST_IDLE = 6'h02,
      ST_ADC_NR = 6'h04,
      ST_PWR_DOWN = 6'h08,
      ST_PWR_SAVE = 6'h10,
      ST_STANDBY = 6'h20
   } sleep_state_t;

   // clock enables for each domain
   typedef struct packed {
      logic cpu;
      logic mem;
      logic timers;
      logic spi;
      logic irq;
      logic adc;
      logic async_tmr;
      logic main_osc;
   } clk_en_t;

   localparam clk_en_t CLK_EN_ALL = 8'hFF;
   localparam logic [7:0] PORT_WIDTH = 8'h08;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam sleep_state_t STATE_RESET = ST_ACTIVE;
endpackage

// >>> design/sleep_mode_clock_gating.sv
// sleep mode controller: per-mode clock gating, wake-up, oscillator pin use
// Functional notes
// - five software-selected sleep modes exist besides the active state.
// - idle stops only the processor clock; memory, timers, spi and interrupts run.
// - power-down stops the main oscillator and all else; only interrupt or reset wakes.
// - power-down keeps all register contents unchanged.
// - power-save keeps the asynchronous timer counting while the rest sleeps.
// - adc noise reduction stops cpu and i/o except asynchronous timer, adc and interrupts.
// - standby keeps the main oscillator running while the rest sleeps.
// - with internal rc clock and async select set, the oscillator pin pair feeds the timer.
// - any active reset tri-states the port drivers at once, without a clock.
`timescale 1ns/1ps
module sleep_mode_clock_gating (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic sleep_req_i,
   input wire sleep_ctrl_pkg::sleep_sel_t sleep_sel_i,
   input wire logic irq_wake_i,
   input wire logic any_wake_i,
   input wire logic int_rc_clk_sel_i,
   input wire logic async_timer_clock_select_i,
   input wire logic [7:0] port_out_i,
   input wire logic [7:0] port_dir_i,
   output sleep_ctrl_pkg::clk_en_t clk_en_o,
   output sleep_ctrl_pkg::sleep_state_t state_o,
   output logic sleeping_o,
   output logic osc_pin_pair_timer_o,
   output logic [7:0] port_o,
   output logic [7:0] port_oe_o
);
   import sleep_ctrl_pkg::*;

   sleep_state_t state_q;
   sleep_state_t state_d;
   sleep_state_t enter_state;
   clk_en_t clk_en_d;
   clk_en_t clk_en_q;
   logic [PORT_WIDTH-1:0] port_q;
   logic [PORT_WIDTH-1:0] dir_q;
   logic valid_sel;
   logic wake;
   logic in_active;

   assign in_active = (state_q == ST_ACTIVE);
   // power-down wakes on interrupt only; others on any wake source
   assign wake = (state_q == ST_PWR_DOWN) ? irq_wake_i : (irq_wake_i | any_wake_i);

   // mode decode; unknown codes are ignored so the cpu never sticks
   assign valid_sel = (sleep_sel_i == SEL_IDLE) || (sleep_sel_i == SEL_ADC_NR) ||
                      (sleep_sel_i == SEL_PWR_DOWN) || (sleep_sel_i == SEL_PWR_SAVE) ||
                      (sleep_sel_i == SEL_STANDBY);
   assign enter_state = (sleep_sel_i == SEL_IDLE) ? ST_IDLE :
                        (sleep_sel_i == SEL_ADC_NR) ? ST_ADC_NR :
                        (sleep_sel_i == SEL_PWR_DOWN) ? ST_PWR_DOWN :
                        (sleep_sel_i == SEL_PWR_SAVE) ? ST_PWR_SAVE : ST_STANDBY;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_ACTIVE: begin
            if (sleep_req_i && valid_sel) begin
               state_d = enter_state;
            end
         end
         default: begin
            if (wake) begin
               state_d = ST_ACTIVE;
            end
         end
      endcase
   end

   // clock enables per mode
   always_comb begin
      clk_en_d = '0;
      case (state_d)
         ST_ACTIVE: clk_en_d = CLK_EN_ALL;
         ST_IDLE: begin
            clk_en_d = CLK_EN_ALL;
            clk_en_d.cpu = 1'b0;
         end
         ST_ADC_NR: begin
            clk_en_d.adc = 1'b1;
            clk_en_d.async_tmr = 1'b1;
            clk_en_d.irq = 1'b1;
            clk_en_d.main_osc = 1'b1;
         end
         ST_PWR_SAVE: begin
            clk_en_d.async_tmr = 1'b1;
         end
         ST_STANDBY: begin
            clk_en_d.main_osc = 1'b1;
         end
         default: clk_en_d = '0;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         state_q <= STATE_RESET;
         clk_en_q <= CLK_EN_ALL;
      end else begin
         state_q <= state_d;
         clk_en_q <= clk_en_d;
      end
   end

   // port registers load only while active, so sleep holds them
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         port_q <= PORT_RESET;
         dir_q <= DIR_RESET;
      end else if (in_active) begin
         port_q <= port_out_i;
         dir_q <= port_dir_i;
      end
   end

   assign clk_en_o = clk_en_q;
   assign state_o = state_q;
   assign sleeping_o = !in_active;
   assign osc_pin_pair_timer_o = int_rc_clk_sel_i & async_timer_clock_select_i;
   assign port_o = port_q;
   // reset gates enables combinationally, no clock edge needed
   assign port_oe_o = reset_n_i ? dir_q : 8'h00;

   // steps of a sleep round trip: request taken or refused, quiet sleep, wake taken, back to full clocks
   sequence s_sleep_taken;
      in_active && sleep_req_i && valid_sel;
   endsequence

   sequence s_bad_request;
      in_active && sleep_req_i && !valid_sel;
   endsequence

   sequence s_wake_taken;
      !in_active && wake;
   endsequence

   sequence s_quiet_sleep;
      !in_active && !wake;
   endsequence

   sequence s_back_active;
      in_active && (clk_en_q == CLK_EN_ALL);
   endsequence

   a_idle_cpu_off: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_q == ST_IDLE) |-> (!clk_en_q.cpu && clk_en_q.mem && clk_en_q.timers &&
      clk_en_q.spi && clk_en_q.irq)) else $error("idle gating wrong");
   a_pdown_all_off: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_q == ST_PWR_DOWN) |-> (clk_en_q == 8'h00)) else $error("power-down not off");
   a_pdown_irq_only: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_q == ST_PWR_DOWN && !irq_wake_i) |=> (state_q == ST_PWR_DOWN))
      else $error("power-down left without interrupt");
   a_sleep_holds: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !in_active |=> ($stable(port_q) && $stable(dir_q))) else $error("state lost");
   a_psave_async: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_q == ST_PWR_SAVE) |-> (clk_en_q.async_tmr && !clk_en_q.cpu && !clk_en_q.main_osc))
      else $error("power-save gating wrong");
   a_adc_nr_run: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_q == ST_ADC_NR) |-> (clk_en_q.adc && clk_en_q.async_tmr && !clk_en_q.cpu &&
      !clk_en_q.spi && !clk_en_q.timers)) else $error("adc noise gating wrong");
   a_standby_osc: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_q == ST_STANDBY) |-> (clk_en_q == 8'h01)) else $error("standby gating wrong");
   a_pin_pair: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      osc_pin_pair_timer_o == (int_rc_clk_sel_i && async_timer_clock_select_i))
      else $error("pin pair select wrong");
   a_reset_tristate: assert property (@(posedge ref_clk_i)
      !reset_n_i |-> (port_oe_o == 8'h00)) else $error("ports driven in reset");
   a_wake_restore: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_wake_taken |=> s_back_active) else $error("wake failed");
   a_sleep_enter: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_sleep_taken |=> (!in_active && (state_q == $past(enter_state))))
      else $error("sleep not entered");

   property p_state_onehot;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      $onehot(state_q);
   endproperty
   a_state_onehot: assert property (p_state_onehot)
      else $error("state not one-hot");

   property p_bad_sel_ignored;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_bad_request |=> s_back_active;
   endproperty
   a_bad_sel_ignored: assert property (p_bad_sel_ignored)
      else $error("reserved code entered sleep");

   property p_sleep_flag;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sleeping_o == (state_q != ST_ACTIVE);
   endproperty
   a_sleep_flag: assert property (p_sleep_flag)
      else $error("sleep flag wrong");

   // asleep with no wake source, neither the state nor the enables may move
   property p_sleep_steady;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_quiet_sleep |=> ($stable(state_q) && $stable(clk_en_q));
   endproperty
   a_sleep_steady: assert property (p_sleep_steady)
      else $error("sleep state moved");

   property p_pdown_any_ignored;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_q == ST_PWR_DOWN && any_wake_i && !irq_wake_i) |=>
      (state_q == ST_PWR_DOWN && clk_en_q == 8'h00);
   endproperty
   a_pdown_any_ignored: assert property (p_pdown_any_ignored)
      else $error("power-down woke without interrupt");

   property p_ports_load;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      in_active |=> (port_q == $past(port_out_i) && dir_q == $past(port_dir_i));
   endproperty
   a_ports_load: assert property (p_ports_load)
      else $error("port load wrong");

   property p_active_all_on;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_q == ST_ACTIVE) |-> (clk_en_q == CLK_EN_ALL);
   endproperty
   a_active_all_on: assert property (p_active_all_on)
      else $error("active clocks gated");

   // no disable on these two: they watch the reset itself
   property p_reset_wakes;
      @(posedge ref_clk_i)
      !reset_n_i |=> (state_q == STATE_RESET && clk_en_q == CLK_EN_ALL &&
      port_q == PORT_RESET && dir_q == DIR_RESET);
   endproperty
   a_reset_wakes: assert property (p_reset_wakes)
      else $error("reset did not end sleep");

   property p_oe_follows_dir;
      @(posedge ref_clk_i)
      reset_n_i |-> (port_oe_o == dir_q);
   endproperty
   a_oe_follows_dir: assert property (p_oe_follows_dir)
      else $error("enable not from direction");
endmodule // sleep_mode_clock_gating

// >>> testbench/tb_sleep_mode_clock_gating.sv
// testbench: sleep modes, wake-up, port reset, oscillator pin use
`timescale 1ns/1ps
module tb_sleep_mode_clock_gating;
   import sleep_ctrl_pkg::*;
   logic ref_clk_i = 0, reset_n_i = 0, sleep_req_i = 0, irq_wake_i = 0, any_wake_i = 0;
   logic int_rc_clk_sel_i = 0, async_timer_clock_select_i = 0;
   logic [7:0] port_out_i = 8'h00, port_dir_i = 8'h00, port_o, port_oe_o;
   sleep_sel_t sleep_sel_i = SEL_IDLE;
   clk_en_t clk_en_o;
   sleep_state_t state_o;
   logic sleeping_o, osc_pin_pair_timer_o;
   int fail_count = 0, check_count = 0;
   sleep_mode_clock_gating sleep_mode_clock_gating_inst (.ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i), .sleep_req_i(sleep_req_i), .sleep_sel_i(sleep_sel_i),
      .irq_wake_i(irq_wake_i), .any_wake_i(any_wake_i), .int_rc_clk_sel_i(int_rc_clk_sel_i),
      .async_timer_clock_select_i(async_timer_clock_select_i), .port_out_i(port_out_i),
      .port_dir_i(port_dir_i), .clk_en_o(clk_en_o), .state_o(state_o),
      .sleeping_o(sleeping_o), .osc_pin_pair_timer_o(osc_pin_pair_timer_o),
      .port_o(port_o), .port_oe_o(port_oe_o));
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   task automatic tick();
      @(posedge ref_clk_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // enter a mode, check gating, then wake by interrupt
   task automatic mode_cycle(input sleep_sel_t sel, input logic [7:0] en, input sleep_state_t st);
      sleep_req_i = 1;
      sleep_sel_i = sel;
      tick();
      sleep_req_i = 0;
      chk(clk_en_o, en);
      chk({2'h0, state_o}, {2'h0, st});
      chk({7'h00, sleeping_o}, 8'h01);
      irq_wake_i = 1;
      tick();
      irq_wake_i = 0;
      chk(clk_en_o, 8'hFF);
      chk({2'h0, state_o}, {2'h0, ST_ACTIVE});
      chk({7'h00, sleeping_o}, 8'h00);
   endtask
   // the other wake source ends every mode but power-down
   task automatic wake_other(input sleep_sel_t sel, input sleep_state_t st);
      sleep_req_i = 1;
      sleep_sel_i = sel;
      tick();
      sleep_req_i = 0;
      chk({2'h0, state_o}, {2'h0, st});
      any_wake_i = 1;
      tick();
      any_wake_i = 0;
      chk({2'h0, state_o}, {2'h0, ST_ACTIVE});
      chk(clk_en_o, 8'hFF);
   endtask
   // power-down: other wakes ignored, port state held
   task automatic pdown_hold();
      port_out_i = 8'h5A;
      port_dir_i = 8'hF0;
      tick();
      sleep_req_i = 1;
      sleep_sel_i = SEL_PWR_DOWN;
      tick();
      sleep_req_i = 0;
      any_wake_i = 1;
      port_out_i = 8'hA5;
      port_dir_i = 8'h0F;
      tick();
      tick();
      any_wake_i = 0;
      chk(clk_en_o, 8'h00);
      chk(port_o, 8'h5A);
      chk(port_oe_o, 8'hF0);
      mode_cycle(SEL_PWR_DOWN, 8'h00, ST_PWR_DOWN);
      tick();
      chk(port_o, 8'hA5);
      chk(port_oe_o, 8'h0F);
   endtask
   // reserved select codes refused; request held level across them
   task automatic refused();
      sleep_req_i = 1;
      for (int c = 4; c < 8; c++) begin
         if (c != 6) begin
            sleep_sel_i = sleep_sel_t'(c[2:0]);
            tick();
            chk({2'h0, state_o}, {2'h0, ST_ACTIVE});
            chk({7'h00, sleeping_o}, 8'h00);
         end
      end
      sleep_req_i = 0;
   endtask
   // pin pair only with internal rc and async select both set
   task automatic pin_pair();
      for (int i = 0; i < 4; i++) begin
         {int_rc_clk_sel_i, async_timer_clock_select_i} = i[1:0];
         tick();
         chk({7'h00, osc_pin_pair_timer_o}, {7'h00, i == 3});
      end
   endtask
   // reset in mid-run: ports tri-state without a clock edge, power-down ends
   task automatic reset_tristate();
      port_out_i = 8'h3C;
      port_dir_i = 8'hFF;
      tick();
      chk(port_oe_o, 8'hFF);
      sleep_req_i = 1;
      sleep_sel_i = SEL_PWR_DOWN;
      tick();
      sleep_req_i = 0;
      chk({2'h0, state_o}, {2'h0, ST_PWR_DOWN});
      reset_n_i = 0;
      #1;
      chk(port_oe_o, 8'h00);
      tick();
      chk({2'h0, state_o}, {2'h0, ST_ACTIVE});
      chk(clk_en_o, 8'hFF);
      chk(port_o, 8'h00);
      reset_n_i = 1;
      tick();
      chk(port_o, 8'h3C);
      chk(port_oe_o, 8'hFF);
   endtask
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (16) tick();
      chk(port_oe_o, 8'h00);
      chk({2'h0, state_o}, {2'h0, ST_ACTIVE});
      chk(port_o, 8'h00);
      reset_n_i = 1;
      chk(clk_en_o, 8'hFF);
      mode_cycle(SEL_IDLE, 8'h7F, ST_IDLE);
      mode_cycle(SEL_ADC_NR, 8'h0F, ST_ADC_NR);
      mode_cycle(SEL_PWR_SAVE, 8'h02, ST_PWR_SAVE);
      mode_cycle(SEL_STANDBY, 8'h01, ST_STANDBY);
      pdown_hold();
      wake_other(SEL_IDLE, ST_IDLE);
      wake_other(SEL_ADC_NR, ST_ADC_NR);
      wake_other(SEL_PWR_SAVE, ST_PWR_SAVE);
      wake_other(SEL_STANDBY, ST_STANDBY);
      refused();
      pin_pair();
      reset_tristate();
      finish_test();
   end
endmodule // tb_sleep_mode_clock_gating
